/* smx_regs.svh */
// Register map, field positions, reset values and timing of the mux bank
`ifndef SMX_REGS_SVH
`define SMX_REGS_SVH

// Register addresses on the serial link
`define SMX_ADDR_SWITCH     7'h01
`define SMX_ADDR_ERR_EN     7'h02
`define SMX_ADDR_ERR_FLAGS  7'h03
`define SMX_ADDR_BURST      7'h05
`define SMX_ADDR_CYC_EN     7'h06
`define SMX_ADDR_CYC_MASK   7'h07
`define SMX_ADDR_CYC_EDGE   7'h09
`define SMX_ADDR_SW_RESET   7'h0b

// Error enable and error flag bit positions
`define SMX_BIT_RW          2
`define SMX_BIT_SCLK        1
`define SMX_BIT_CRC         0

// Reset values and writable masks
`define SMX_RST_SWITCH      8'h00
`define SMX_RST_ERR_EN      8'h06
`define SMX_RST_MASK_EIGHT  8'hff
`define SMX_RST_MASK_PAIR   8'h0f
`define SMX_WMASK_ERR_EN    8'h07
`define SMX_WMASK_BIT0      8'h01

// Special commands and keys
`define SMX_CLEAR_CMD       16'h6ca9
`define SMX_SRST_KEY1       8'ha3
`define SMX_SRST_KEY2       8'h05
`define SMX_EXIT_CMD1       16'ha318
`define SMX_EXIT_CMD2       16'he3b4
`define SMX_ALIGN           8'h25
`define SMX_CRC_POLY        8'h07

// Frame lengths in link clocks
`define SMX_LEN_PLAIN       5'h10
`define SMX_LEN_CRC         5'h18
`define SMX_LEN_CMD         5'h10
`define SMX_LEN_ADDR        5'h08

// Host controller register offsets
`define SMX_HOST_CMD        2'h0
`define SMX_HOST_CTRL       2'h1
`define SMX_HOST_STATUS     2'h2
`define SMX_HOST_RDATA      2'h3

// Link clock timing
`define SMX_CLK_PERIOD_NS   50
`define SMX_SCLK_PERIOD_NS  400
`define SMX_HALF_CYC  (`SMX_SCLK_PERIOD_NS / (2 * `SMX_CLK_PERIOD_NS))

`endif

/* smx_pkg.sv */
// Types shared by both ends of the mux serial link
package smx_pkg;

    typedef enum logic [1:0] {
        SMX_IDLE  = 2'b01,
        SMX_SHIFT = 2'b10
    } smx_link_state_t;

    typedef enum logic [4:0] {
        SMX_H_IDLE  = 5'b00001,
        SMX_H_SETUP = 5'b00010,
        SMX_H_LOW   = 5'b00100,
        SMX_H_HIGH  = 5'b01000,
        SMX_H_TAIL  = 5'b10000
    } smx_host_state_t;

    typedef struct packed {
        logic [1:0]      cs_sync;
        logic [1:0]      sclk_sync;
        logic [1:0]      sdi_sync;
        logic [1:0]      cnv_sync;
        logic            cs_prev;
        logic            sclk_prev;
        logic            cnv_prev;
        smx_link_state_t state;
        logic [4:0]      bitpos;
        logic [1:0]      words;
        logic [23:0]     shin;
        logic [7:0]      crc;
        logic [8:0]      sdo_sh;
        logic [15:0]     pend;
        logic            pend_ok;
        logic            pend_v;
        logic [7:0]      sw;
        logic [7:0]      err_en;
        logic [7:0]      flags;
        logic [7:0]      burst;
        logic [7:0]      cyc_en;
        logic [7:0]      mask;
        logic [7:0]      edge_sel;
        logic            rst_arm;
        logic            exit_arm;
        logic [2:0]      chan;
        logic [7:0]      sw_on;
        logic [4:0]      aux;
        logic            sdo;
    } smx_dev_t;

    typedef struct packed {
        smx_host_state_t state;
        logic [7:0]      div;
        logic [4:0]      bitcnt;
        logic [4:0]      flen;
        logic [23:0]     shout;
        logic [15:0]     shin;
        logic [7:0]      crc;
        logic            crc_on;
        logic [15:0]     rdata;
        logic [15:0]     bus_rd;
        logic [1:0]      sdo_sync;
        logic            cs_n;
        logic            sclk;
        logic            sdi;
    } smx_host_t;

endpackage : smx_pkg

/* smx_spi_if.sv */
// Serial link between the host controller and the mux register bank
`timescale 1ns/1ps
interface smx_spi_if;
    logic cs_n;
    logic sclk;
    logic sdi;
    logic sdo;

    modport device (
        input  cs_n,
        input  sclk,
        input  sdi,
        output sdo
    );

    modport host (
        output cs_n,
        output sclk,
        output sdi,
        input  sdo
    );
endinterface : smx_spi_if

/* smx_device.sv */
// Mux register bank: serial frame decode, registers, switch and output decode
//
// Behaviour
// - Switch select drives closed switch and outputs
// - Enable low: none on; else switch code+1
// - Upper select bits drive auxiliary outputs
// - Error enables reset with CRC check off
// - Enable bits gate address, count, CRC checks
// - Expect 16 or 24 clocks, multiples in burst
// - CRC on makes every frame 24 bits
// - Error flags read-only, reset zero
// - Dedicated command clears all error flags
// - Clear command never flags invalid address
// - With CRC on, clear needs correct CRC
// - Read of missing address flags invalid address
// - Write to missing or read-only flags error
// - Wrong clock count sets count flag
// - Bad CRC on write sets CRC flag
// - Burst mode accepts back-to-back commands
// - Host writes zero to reserved bits
// - Two-step unlock writes cause software reset
// - Cycling steps enabled channels in ascending order
// - Edge select picks strobe stepping edge
// - Cycling mode forces auxiliary outputs low
`timescale 1ns/1ps
`include "smx_regs.svh"
module smx_device
    import smx_pkg::*;
#(
    parameter bit FOUR_PAIR = 1'b0
) (
    // Clock and reset
    input  wire logic   clock_in,
    input  wire logic   rst_n_in,
    // Serial link
    smx_spi_if.device   link,
    // Conversion strobe for channel cycling
    input  wire logic   conversion_strobe_in,
    // Switch and auxiliary outputs
    output logic [7:0]  switch_on_out,
    output logic [4:0]  aux_out
);

    localparam logic [7:0] MASK_RST = FOUR_PAIR ? `SMX_RST_MASK_PAIR
                                                : `SMX_RST_MASK_EIGHT;

    smx_dev_t s;
    smx_dev_t n;

    // Register defaults, used by hard and software reset
    function automatic smx_dev_t dev_defaults(input smx_dev_t cur);
        smx_dev_t r;
        r          = cur;
        r.sw       = `SMX_RST_SWITCH;
        r.err_en   = `SMX_RST_ERR_EN;
        r.flags    = 8'h00;
        r.burst    = 8'h00;
        r.cyc_en   = 8'h00;
        r.mask     = MASK_RST;
        r.edge_sel = 8'h00;
        r.rst_arm  = 1'b0;
        r.exit_arm = 1'b0;
        r.chan     = 3'h0;
        return r;
    endfunction : dev_defaults

    // Next enabled channel above the current one, wrapping to the lowest
    function automatic logic [2:0] next_chan(input logic [2:0] ch,
                                             input logic [7:0] m);
        logic [2:0] r;
        logic [2:0] c;
        r = ch;
        for (int i = 7; i >= 1; i--)
        begin
            c = ch + 3'(i);
            if (m[c])
                r = c;
        end
        return r;
    endfunction : next_chan

    // Register readback, reserved bits already zero in storage
    function automatic logic [7:0] read_reg(input smx_dev_t st,
                                            input logic [6:0] a);
        case (a)
            `SMX_ADDR_SWITCH:    read_reg = st.sw;
            `SMX_ADDR_ERR_EN:    read_reg = st.err_en;
            `SMX_ADDR_ERR_FLAGS: read_reg = st.flags;
            `SMX_ADDR_BURST:     read_reg = st.burst;
            `SMX_ADDR_CYC_EN:    read_reg = st.cyc_en;
            `SMX_ADDR_CYC_MASK:  read_reg = st.mask;
            `SMX_ADDR_CYC_EDGE:  read_reg = st.edge_sel;
            default:             read_reg = 8'h00;
        endcase
    endfunction : read_reg

    function automatic logic addr_valid(input logic [6:0] a);
        case (a)
            `SMX_ADDR_SWITCH, `SMX_ADDR_ERR_EN, `SMX_ADDR_ERR_FLAGS,
            `SMX_ADDR_BURST, `SMX_ADDR_CYC_EN, `SMX_ADDR_CYC_MASK,
            `SMX_ADDR_CYC_EDGE, `SMX_ADDR_SW_RESET: addr_valid = 1'b1;
            default:                                 addr_valid = 1'b0;
        endcase
    endfunction : addr_valid

    // Frame decode, command execution and output decode
    always_comb
    begin
        logic        sclk_rise;
        logic        sclk_fall;
        logic        cs_fall;
        logic        cs_rise;
        logic        cnv_edge;
        logic        crc_mode;
        logic        do_exec;
        logic        ex_ok;
        logic        clr;
        logic        fb;
        logic [15:0] ex_word;
        logic [23:0] sh;
        logic [7:0]  crc_nx;
        logic [7:0]  sets;
        logic [6:0]  ex_addr;
        logic [7:0]  ex_data;
        logic [4:0]  flen;
        logic [2:0]  code;
        n         = s;
        sclk_rise = ~s.sclk_prev & s.sclk_sync[1];
        sclk_fall = s.sclk_prev & ~s.sclk_sync[1];
        cs_fall   = s.cs_prev & ~s.cs_sync[1];
        cs_rise   = ~s.cs_prev & s.cs_sync[1];
        crc_mode  = s.err_en[`SMX_BIT_CRC];
        flen      = crc_mode ? `SMX_LEN_CRC : `SMX_LEN_PLAIN;
        do_exec   = 1'b0;
        ex_ok     = 1'b0;
        ex_word   = 16'h0000;
        clr       = 1'b0;
        sets      = 8'h00;
        sh        = {s.shin[22:0], s.sdi_sync[1]};
        fb        = s.crc[7] ^ s.sdi_sync[1];
        crc_nx    = {s.crc[6:0], 1'b0} ^ (fb ? `SMX_CRC_POLY : 8'h00);
        // Input synchronisers, first stage read only by the second
        n.cs_sync   = {s.cs_sync[0], link.cs_n};
        n.sclk_sync = {s.sclk_sync[0], link.sclk};
        n.sdi_sync  = {s.sdi_sync[0], link.sdi};
        n.cnv_sync  = {s.cnv_sync[0], conversion_strobe_in};
        n.cs_prev   = s.cs_sync[1];
        n.sclk_prev = s.sclk_sync[1];
        n.cnv_prev  = s.cnv_sync[1];
        cnv_edge = s.edge_sel[0] ? (~s.cnv_prev & s.cnv_sync[1])
                                 : (s.cnv_prev & ~s.cnv_sync[1]);

        // Link framing
        if (cs_fall)
        begin
            n.state  = SMX_SHIFT;
            n.bitpos = 5'h00;
            n.words  = 2'h0;
            n.crc    = 8'h00;
            n.pend_v = 1'b0;
            n.sdo_sh = {`SMX_ALIGN, 1'b0};
        end
        else if (s.state == SMX_SHIFT && sclk_rise)
        begin
            n.shin   = sh;
            n.bitpos = s.bitpos + 5'h01;
            if (s.bitpos < `SMX_LEN_CMD)
                n.crc = crc_nx;
            if (s.bitpos + 5'h01 == `SMX_LEN_ADDR)
                n.sdo_sh = {s.sdo_sh[8],
                            sh[7] ? read_reg(s, sh[6:0]) : 8'h00};
            if (s.bitpos + 5'h01 == flen)
            begin
                n.bitpos = 5'h00;
                n.words  = (s.words == 2'h3) ? 2'h3 : s.words + 2'h1;
                n.sdo_sh = {s.sdo_sh[8], `SMX_ALIGN};
                ex_word  = crc_mode ? sh[23:8] : sh[15:0];
                ex_ok    = ~crc_mode | (sh[7:0] == s.crc);
                if (s.burst[0])
                    do_exec = 1'b1;
                else if (s.words == 2'h0)
                begin
                    n.pend    = ex_word;
                    n.pend_ok = ex_ok;
                    n.pend_v  = 1'b1;
                end
            end
        end
        else if (s.state == SMX_SHIFT && sclk_fall)
            n.sdo_sh = {s.sdo_sh[7:0], 1'b0};
        else if (s.state == SMX_SHIFT && cs_rise)
        begin
            n.state = SMX_IDLE;
            if (s.bitpos != 5'h00 || s.words == 2'h0
                || (!s.burst[0] && s.words != 2'h1))
                sets[`SMX_BIT_SCLK] = s.err_en[`SMX_BIT_SCLK];
            else if (!s.burst[0] && s.pend_v)
            begin
                do_exec = 1'b1;
                ex_word = s.pend;
                ex_ok   = s.pend_ok;
            end
        end

        // Command execution
        ex_addr = ex_word[14:8];
        ex_data = ex_word[7:0];
        if (do_exec)
        begin
            if (!ex_ok)
                sets[`SMX_BIT_CRC] = ~ex_word[15]
                                     & s.err_en[`SMX_BIT_CRC];
            else if (s.cyc_en[0])
            begin
                n.exit_arm = (ex_word == `SMX_EXIT_CMD1);
                if (s.exit_arm && ex_word == `SMX_EXIT_CMD2)
                    n.cyc_en = 8'h00;
            end
            else if (ex_word == `SMX_CLEAR_CMD)
                clr = 1'b1;
            else if (ex_word[15])
                sets[`SMX_BIT_RW] = ~addr_valid(ex_addr)
                                    & s.err_en[`SMX_BIT_RW];
            else
            begin
                n.rst_arm = 1'b0;
                case (ex_addr)
                    `SMX_ADDR_SWITCH:   n.sw = ex_data;
                    `SMX_ADDR_ERR_EN:
                        n.err_en = ex_data & `SMX_WMASK_ERR_EN;
                    `SMX_ADDR_BURST:
                        n.burst = ex_data & `SMX_WMASK_BIT0;
                    `SMX_ADDR_CYC_EN:
                    begin
                        n.cyc_en = ex_data & `SMX_WMASK_BIT0;
                        n.chan   = next_chan(3'h7, s.mask);
                    end
                    `SMX_ADDR_CYC_MASK: n.mask = ex_data & MASK_RST;
                    `SMX_ADDR_CYC_EDGE:
                        n.edge_sel = ex_data & `SMX_WMASK_BIT0;
                    `SMX_ADDR_SW_RESET:
                    begin
                        n.rst_arm = (ex_data == `SMX_SRST_KEY1);
                        if (s.rst_arm && ex_data == `SMX_SRST_KEY2)
                        begin
                            n   = dev_defaults(n);
                            clr = 1'b1;
                        end
                    end
                    default:
                        sets[`SMX_BIT_RW] = s.err_en[`SMX_BIT_RW];
                endcase
            end
        end
        // Set wins over clear
        n.flags = (clr ? 8'h00 : s.flags) | sets;

        // Channel cycling steps on the active strobe edge
        if (s.cyc_en[0] && cnv_edge)
            n.chan = next_chan(s.chan, s.mask);

        // Switch and output decode
        code = FOUR_PAIR ? {1'b0, s.sw[2:1]} : s.sw[3:1];
        if (s.cyc_en[0])
            n.sw_on = 8'h01 << s.chan;
        else if (s.sw[0])
            n.sw_on = 8'h01 << code;
        else
            n.sw_on = 8'h00;
        if (s.cyc_en[0])
            n.aux = 5'h00;
        else
            n.aux = FOUR_PAIR ? s.sw[7:3] : {1'b0, s.sw[7:4]};
        n.sdo = n.sdo_sh[8];

        if (!rst_n_in)
        begin
            n           = dev_defaults('0);
            n.state     = SMX_IDLE;
            n.cs_sync   = 2'b11;
            n.cs_prev   = 1'b1;
        end
    end

    // State register
    always_ff @(posedge clock_in)
    begin
        s <= n;
    end

    // Outputs straight from flip-flops
    assign switch_on_out = s.sw_on;
    assign aux_out       = s.aux;
    assign link.sdo      = s.sdo;

endmodule : smx_device

/* smx_host.sv */
// Host controller: sends one serial frame per command register write
`timescale 1ns/1ps
`include "smx_regs.svh"
module smx_host
    import smx_pkg::*;
#(
    parameter int HALF_CYC = `SMX_HALF_CYC
) (
    // Clock and reset
    input  wire logic        clock_in,
    input  wire logic        rst_n_in,
    // Serial link
    smx_spi_if.host          link,
    // Register port
    input  wire logic [1:0]  addr_in,
    input  wire logic [15:0] wdata_in,
    input  wire logic        write_in,
    input  wire logic        read_in,
    output logic [15:0]      rdata_out
);

    localparam logic [7:0] HALF_LAST = 8'(HALF_CYC - 1);

    smx_host_t s;
    smx_host_t n;

    // Frame sequencing, CRC generation and register port
    always_comb
    begin
        logic       half_done;
        logic       fb;
        logic [7:0] crc_nx;
        n         = s;
        half_done = (s.div == HALF_LAST);
        fb        = s.crc[7] ^ s.sdi;
        crc_nx    = {s.crc[6:0], 1'b0} ^ (fb ? `SMX_CRC_POLY : 8'h00);
        n.sdo_sync = {s.sdo_sync[0], link.sdo};
        n.div      = half_done ? 8'h00 : s.div + 8'h01;
        n.bus_rd   = 16'h0000;

        case (s.state)
            SMX_H_IDLE:
            begin
                n.div = 8'h00;
                if (write_in && addr_in == `SMX_HOST_CMD)
                begin
                    n.state  = SMX_H_SETUP;
                    n.cs_n   = 1'b0;
                    n.shout  = {wdata_in, 8'h00};
                    n.sdi    = wdata_in[15];
                    n.crc    = 8'h00;
                    n.bitcnt = 5'h00;
                    n.flen   = s.crc_on ? `SMX_LEN_CRC : `SMX_LEN_PLAIN;
                end
            end
            SMX_H_SETUP:
                if (half_done)
                    n.state = SMX_H_LOW;
            SMX_H_LOW:
                if (half_done)
                begin
                    n.state = SMX_H_HIGH;
                    n.sclk  = 1'b1;
                    if (s.bitcnt < `SMX_LEN_CMD)
                        n.crc = crc_nx;
                end
            SMX_H_HIGH:
                if (half_done)
                begin
                    n.sclk   = 1'b0;
                    n.bitcnt = s.bitcnt + 5'h01;
                    if (s.bitcnt < `SMX_LEN_CMD)
                        n.shin = {s.shin[14:0], s.sdo_sync[1]};
                    n.shout = {s.shout[22:0], 1'b0};
                    if (s.bitcnt + 5'h01 == `SMX_LEN_CMD)
                        n.shout = {s.crc, 16'h0000};
                    n.sdi   = n.shout[23];
                    n.state = (s.bitcnt + 5'h01 == s.flen) ? SMX_H_TAIL
                                                           : SMX_H_LOW;
                end
            SMX_H_TAIL:
                if (half_done)
                begin
                    n.cs_n  = 1'b1;
                    n.sdi   = 1'b0;
                    n.rdata = s.shin;
                    n.state = SMX_H_IDLE;
                end
            default:
                n.state = SMX_H_IDLE;
        endcase

        // Control register write; command word is the frame itself
        if (write_in && addr_in == `SMX_HOST_CTRL)
            n.crc_on = wdata_in[0];
        if (read_in)
        begin
            case (addr_in)
                `SMX_HOST_CTRL:   n.bus_rd = {15'h0000, s.crc_on};
                `SMX_HOST_STATUS:
                    n.bus_rd = {15'h0000, s.state != SMX_H_IDLE};
                `SMX_HOST_RDATA:  n.bus_rd = s.rdata;
                default:          n.bus_rd = 16'h0000;
            endcase
        end

        if (!rst_n_in)
        begin
            n       = '0;
            n.state = SMX_H_IDLE;
            n.cs_n  = 1'b1;
        end
    end

    // State register
    always_ff @(posedge clock_in)
    begin
        s <= n;
    end

    // Outputs straight from flip-flops
    assign link.cs_n = s.cs_n;
    assign link.sclk = s.sclk;
    assign link.sdi  = s.sdi;
    assign rdata_out = s.bus_rd;

endmodule : smx_host

/* smx_link_sva.sv */
// Concurrent checks on the serial link and the mux outputs
`timescale 1ns/1ps
module smx_link_sva #(
    parameter bit FOUR_PAIR = 1'b0
) (
    // Clock and reset
    input  wire logic       clock_in,
    input  wire logic       rst_n_in,
    // Serial link
    input  wire logic       cs_n,
    input  wire logic       sclk,
    input  wire logic       sdi,
    input  wire logic       sdo,
    // Mux outputs
    input  wire logic [7:0] switch_on_out,
    input  wire logic [4:0] aux_out
);
    logic       sclk_q;
    logic [5:0] edges;

    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (!rst_n_in);

    // Counts link clock rises inside one frame
    always_ff @(posedge clock_in)
    begin
        sclk_q <= sclk;
        if (!rst_n_in || cs_n)
            edges <= 6'h00;
        else if (sclk && !sclk_q)
            edges <= edges + 6'h01;
    end

    switch_onehot_a: assert property ($onehot0(switch_on_out))
        else $error("more than one switch closed");
    aux_top_low_a: assert property (!FOUR_PAIR |-> !aux_out[4])
        else $error("unused auxiliary output driven");
    reset_quiet_a: assert property ($rose(rst_n_in) |->
        switch_on_out == 8'h00 && aux_out == 5'h00 && cs_n && !sclk)
        else $error("outputs not idle after reset");
    sclk_idle_a: assert property (cs_n |-> !sclk)
        else $error("link clock not low between frames");
    cs_gap_a: assert property ($rose(cs_n) |=> cs_n [*4])
        else $error("chip select gap too short");
    frame_len_a: assert property ($rose(cs_n) |->
        edges == 6'h10 || edges == 6'h18)
        else $error("frame length not 16 or 24 clocks");
    sdi_hold_a: assert property ((sclk && $past(sclk)) |-> $stable(sdi))
        else $error("data changed while link clock high");
    outputs_quiet_a: assert property ((!cs_n && !$past(cs_n) &&
        edges < 6'h10) |-> $stable(switch_on_out) && $stable(aux_out))
        else $error("outputs moved in first word of frame");

    // Main scenarios seen
    cover property ($rose(cs_n) && edges == 6'h18);
    cover property (switch_on_out[7] && aux_out != 5'h00);
    cover property (!cs_n && sdo);
endmodule : smx_link_sva

/* spi_mux_register_bank_tb.sv */
// Self-checking bench: host controller facing the mux register bank
`timescale 1ns/1ps
`include "smx_regs.svh"
module spi_mux_register_bank_tb;
    logic        clock_in;
    logic        rst_n_in;
    logic        strobe;
    logic [1:0]  addr;
    logic [15:0] wdata;
    logic        write;
    logic        read;
    logic [15:0] rdata;
    logic [7:0]  sw_on;
    logic [4:0]  aux;
    logic        crc_on;
    logic [7:0]  v;
    int          failures;
    int          total_checks;
    logic [6:0]  rst_a [8] = '{7'h01, 7'h02, 7'h03, 7'h05,
                               7'h06, 7'h07, 7'h09, 7'h0b};
    logic [7:0]  rst_v [8] = '{8'h00, 8'h06, 8'h00, 8'h00,
                               8'h00, 8'hff, 8'h00, 8'h00};
    logic [6:0]  bad_a [3] = '{7'h04, 7'h03, 7'h7f};

    smx_spi_if link ();

    smx_host u_smx_host (
        .clock_in  (clock_in),
        .rst_n_in  (rst_n_in),
        .link      (link.host),
        .addr_in   (addr),
        .wdata_in  (wdata),
        .write_in  (write),
        .read_in   (read),
        .rdata_out (rdata)
    );

    smx_device #(.FOUR_PAIR(1'b0)) u_smx_device (
        .clock_in             (clock_in),
        .rst_n_in             (rst_n_in),
        .link                 (link.device),
        .conversion_strobe_in (strobe),
        .switch_on_out        (sw_on),
        .aux_out              (aux)
    );

    smx_link_sva #(.FOUR_PAIR(1'b0)) u_smx_link_sva (
        .clock_in      (clock_in),
        .rst_n_in      (rst_n_in),
        .cs_n          (link.cs_n),
        .sclk          (link.sclk),
        .sdi           (link.sdi),
        .sdo           (link.sdo),
        .switch_on_out (sw_on),
        .aux_out       (aux)
    );

    // 20 MHz clock
    initial
    begin
        clock_in = 1'b0;
        forever #25 clock_in = ~clock_in;
    end

    task automatic note(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : note

    task automatic bus_wr(input logic [1:0] a, input logic [15:0] d);
        addr  <= a;
        wdata <= d;
        write <= 1'b1;
        @(posedge clock_in);
        write <= 1'b0;
        @(posedge clock_in);
    endtask : bus_wr

    task automatic bus_rd(input logic [1:0] a, output logic [15:0] d);
        addr <= a;
        read <= 1'b1;
        @(posedge clock_in);
        read <= 1'b0;
        @(posedge clock_in);
        d = rdata;
    endtask : bus_rd

    // One frame on the link, waiting for the host to go idle
    task automatic cmd(input logic [15:0] w);
        logic [15:0] s;
        bus_wr(`SMX_HOST_CMD, w);
        s = 16'h0001;
        for (int i = 0; i < 300 && s[0] !== 1'b0; i++)
            bus_rd(`SMX_HOST_STATUS, s);
        note({7'h00, s[0]}, 8'h00);
        repeat (8) @(posedge clock_in);
    endtask : cmd

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        cmd({1'b0, a, d});
    endtask : wr

    task automatic set_crc(input logic on);
        logic [15:0] d;
        bus_wr(`SMX_HOST_CTRL, {15'h0000, on});
        crc_on = on;
        bus_rd(`SMX_HOST_CTRL, d);
        note(d[7:0], {7'h00, crc_on});
    endtask : set_crc

    task automatic check_reg(input logic [6:0] a, input logic [7:0] exp);
        logic [15:0] d;
        cmd({1'b1, a, 8'h00});
        bus_rd(`SMX_HOST_RDATA, d);
        note(d[7:0], exp);
    endtask : check_reg

    task automatic check_pins(input logic [7:0] es, input logic [4:0] ea);
        note(sw_on, es);
        note({3'h0, aux}, {3'h0, ea});
    endtask : check_pins

    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : results

    // Hang guard, well beyond the expected run
    initial
    begin
        #3_000_000;
        failures++;
        $display("[FAIL] %0t watchdog expired", $time);
        results();
    end

    // Test sequence
    initial
    begin
        rst_n_in = 1'b0;
        strobe = 1'b0;
        addr = 2'h0;
        wdata = 16'h0000;
        write = 1'b0;
        read = 1'b0;
        crc_on = 1'b0;
        v = 8'h00;
        failures = 0;
        total_checks = 0;
        repeat (2) @(posedge clock_in);
        rst_n_in <= 1'b1;
        repeat (4) @(posedge clock_in);
        for (int i = 0; i < 8; i++)
            check_reg(rst_a[i], rst_v[i]);
        check_pins(8'h00, 5'h00);
        $display("test reset values done");
        for (int c = 0; c < 8; c++)
        begin
            v = {4'(c) ^ 4'ha, 3'(c), 1'b1};
            wr(`SMX_ADDR_SWITCH, v);
            check_pins(8'h01 << c, {1'b0, v[7:4]});
            check_reg(`SMX_ADDR_SWITCH, v);
        end
        wr(`SMX_ADDR_SWITCH, 8'hfa);
        check_pins(8'h00, 5'h0f);
        $display("test switch decode done");
        for (int i = 0; i < 3; i++)
        begin
            cmd({i == 0, bad_a[i], 8'h00});
            check_reg(`SMX_ADDR_ERR_FLAGS, 8'h04);
            cmd(`SMX_CLEAR_CMD);
            check_reg(`SMX_ADDR_ERR_FLAGS, 8'h00);
        end
        wr(`SMX_ADDR_ERR_EN, 8'h02);
        cmd({1'b1, 7'h04, 8'h00});
        check_reg(`SMX_ADDR_ERR_FLAGS, 8'h00);
        $display("test address errors done");
        wr(`SMX_ADDR_ERR_EN, 8'h07);
        cmd({1'b1, 7'h04, 8'h00});
        set_crc(1'b1);
        check_reg(`SMX_ADDR_ERR_EN, 8'h07);
        check_reg(`SMX_ADDR_ERR_FLAGS, 8'h02);
        set_crc(1'b0);
        cmd(`SMX_CLEAR_CMD);
        set_crc(1'b1);
        check_reg(`SMX_ADDR_ERR_FLAGS, 8'h02);
        cmd(`SMX_CLEAR_CMD);
        check_reg(`SMX_ADDR_ERR_FLAGS, 8'h00);
        wr(`SMX_ADDR_ERR_EN, 8'h06);
        set_crc(1'b0);
        check_reg(`SMX_ADDR_ERR_EN, 8'h06);
        $display("test crc and count done");
        wr(`SMX_ADDR_SWITCH, 8'hf1);
        wr(`SMX_ADDR_CYC_MASK, 8'h24);
        wr(`SMX_ADDR_CYC_EDGE, 8'h01);
        wr(`SMX_ADDR_CYC_EN, 8'h01);
        check_pins(8'h04, 5'h00);
        strobe <= 1'b1;
        repeat (8) @(posedge clock_in);
        check_pins(8'h20, 5'h00);
        strobe <= 1'b0;
        repeat (8) @(posedge clock_in);
        check_pins(8'h20, 5'h00);
        cmd(`SMX_EXIT_CMD1);
        cmd(`SMX_EXIT_CMD2);
        check_pins(8'h01, 5'h0f);
        $display("test channel cycling done");
        wr(`SMX_ADDR_BURST, 8'h01);
        check_reg(`SMX_ADDR_BURST, 8'h01);
        wr(`SMX_ADDR_SWITCH, 8'h0b);
        check_pins(8'h20, 5'h00);
        wr(`SMX_ADDR_SW_RESET, `SMX_SRST_KEY1);
        wr(`SMX_ADDR_SW_RESET, `SMX_SRST_KEY2);
        check_pins(8'h00, 5'h00);
        check_reg(`SMX_ADDR_BURST, 8'h00);
        check_reg(`SMX_ADDR_SWITCH, 8'h00);
        $display("test burst and reset done");
        results();
    end
endmodule : spi_mux_register_bank_tb
